// *** rtl/pdm_pkg.sv ***
/*
  Package for the peripheral DMA engine: channel numbering in priority
  order, bus and peripheral carriers, transfer cycle costs.
  Assumes a 32-bit system bus shared with the core through an arbiter.
*/
package pdm_pkg;

  localparam int NUM_CH = 11;
  localparam int AW = 32;
  localparam int DW = 32;
  localparam int CW = 16;

  // channel index equals priority rank, 0 highest
  localparam int CH_RX_DBG = 0;
  localparam int CH_RX_SP0 = 1;
  localparam int CH_RX_SP1 = 2;
  localparam int CH_RX_SYN = 3;
  localparam int CH_RX_ADC = 4;
  localparam int CH_RX_SPI = 5;
  localparam int CH_TX_DBG = 6;
  localparam int CH_TX_SP0 = 7;
  localparam int CH_TX_SP1 = 8;
  localparam int CH_TX_SYN = 9;
  localparam int CH_TX_SPI = 10;
  localparam int NUM_RX = 6;

  // bus cycles held per single transfer
  localparam logic [1:0] TX_BUS_CYC = 2'h1;
  localparam logic [1:0] RX_BUS_CYC = 2'h2;

  localparam logic [AW-1:0] ADDR_RST = 32'h00000000;
  localparam logic [CW-1:0] CNT_RST = 16'h0000;
  // word step in bytes, and the count of a buffer's last word
  localparam logic [AW-1:0] ADDR_STEP = 32'h00000004;
  localparam logic [CW-1:0] CNT_LAST = 16'h0001;

  typedef logic [NUM_CH-1:0] pdm_chvec_t;

  // software load of a channel's current or next buffer
  typedef struct packed {
    logic load_cur;
    logic load_nxt;
    logic [3:0] ch;
    logic [AW-1:0] addr;
    logic [CW-1:0] cnt;
  } pdm_load_s;

  // single word on the memory bus
  typedef struct packed {
    logic wr;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } pdm_bus_s;

  // word moving between engine and a peripheral
  typedef struct packed {
    logic [3:0] ch;
    logic [DW-1:0] data;
  } pdm_word_s;

endpackage

// *** rtl/pdm_skid.sv ***
/*
  Two-entry buffer with valid/ready on both sides, used on the path
  from the engine to the transmit peripherals.
  Assumes both sides run on clk.
*/
`timescale 1ns/1ps
module pdm_skid (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire pdm_pkg::pdm_word_s in_word,
  output logic out_valid,
  input wire logic out_ready,
  output pdm_pkg::pdm_word_s out_word
);

  pdm_pkg::pdm_word_s mem_r [2];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_word = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_word;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

// *** rtl/pdm_engine.sv ***
/*
  Eleven-channel peripheral DMA engine with current and next buffer
  per channel, fixed priority and a request/grant link to the bus arbiter.
  Assumes a memory read answered in its strobe cycle and peripheral strobes on clk.
*/
`timescale 1ns/1ps
module pdm_engine (
  input wire logic clk,
  input wire logic rst,
  input wire pdm_pkg::pdm_load_s load,
  input wire pdm_pkg::pdm_chvec_t per_req,
  input wire logic [pdm_pkg::NUM_RX*pdm_pkg::DW-1:0] rx_data,
  output pdm_pkg::pdm_chvec_t per_ack_r,
  output logic bus_req_r,
  input wire logic bus_gnt,
  output pdm_pkg::pdm_bus_s bus_r,
  output logic bus_strb_r,
  input wire logic [pdm_pkg::DW-1:0] bus_rdata,
  output logic tx_valid_r,
  input wire logic tx_ready,
  output pdm_pkg::pdm_word_s tx_word_r,
  output pdm_pkg::pdm_chvec_t end_flag_r
);

  typedef enum {ST_IDLE, ST_REQ, ST_RD, ST_WR1, ST_WR2} pdm_state_e;

  pdm_state_e st_r;
  logic [pdm_pkg::AW-1:0] cur_addr_r [pdm_pkg::NUM_CH];
  logic [pdm_pkg::CW-1:0] cur_cnt_r [pdm_pkg::NUM_CH];
  logic [pdm_pkg::AW-1:0] nxt_addr_r [pdm_pkg::NUM_CH];
  logic [pdm_pkg::CW-1:0] nxt_cnt_r [pdm_pkg::NUM_CH];
  pdm_pkg::pdm_chvec_t eligible;
  logic [3:0] sel;
  logic any_sel;
  logic [3:0] ch_r;
  logic done_pulse;
  logic buf_ready;
  logic buf_valid;
  pdm_pkg::pdm_word_s buf_word;
  pdm_pkg::pdm_word_s tx_in;
  logic pick_rx;
  logic [pdm_pkg::DW-1:0] rx_word;
  logic tx_push;
  logic tx_pop;

  ////////////////////////////////////////////////////////////////////////
  // channel eligibility; transmit channels wait for buffer room

  // a tx pick needs room now: only one transfer is ever in flight,
  // so nothing can take that room before its read data arrives
  // low indices receive
  for (genvar i = 0; i < pdm_pkg::NUM_CH; i++) begin : g_elig
    if (i < pdm_pkg::NUM_RX) begin : g_rx
      assign eligible[i] = per_req[i] && (cur_cnt_r[i] != pdm_pkg::CNT_RST);
    end else begin : g_tx
      assign eligible[i] = per_req[i] && buf_ready &&
                           (cur_cnt_r[i] != pdm_pkg::CNT_RST);
    end
  end

  always_comb begin
    sel = 4'h0;
    any_sel = 1'b0;
    for (int i = pdm_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        sel = 4'(i);
        any_sel = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transfer sequencer

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= ST_IDLE;
      ch_r <= 4'h0;
      bus_req_r <= 1'b0;
      bus_strb_r <= 1'b0;
      bus_r <= '0;
      per_ack_r <= '0;
    end else begin
      bus_strb_r <= 1'b0;
      per_ack_r <= '0;
      case (st_r)
        ST_IDLE: begin
          if (any_sel) begin
            ch_r <= sel;
            bus_req_r <= 1'b1;
            st_r <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (bus_gnt) begin
            if (pick_rx) begin
              bus_r.wr <= 1'b1;
              bus_r.addr <= cur_addr_r[ch_r];
              bus_r.wdata <= rx_word;
              bus_strb_r <= 1'b1;
              st_r <= ST_WR1;
            end else begin
              bus_r.wr <= 1'b0;
              bus_r.addr <= cur_addr_r[ch_r];
              bus_r.wdata <= '0;
              bus_strb_r <= 1'b1;
              bus_req_r <= 1'b0;
              st_r <= ST_RD;
            end
          end
        end
        ST_RD: begin
          per_ack_r[ch_r] <= 1'b1;
          st_r <= ST_IDLE;
        end
        ST_WR1: begin
          bus_strb_r <= 1'b1;
          bus_req_r <= 1'b0;
          st_r <= ST_WR2;
        end
        ST_WR2: begin
          bus_r.wr <= 1'b0;
          per_ack_r[ch_r] <= 1'b1;
          st_r <= ST_IDLE;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign done_pulse = (st_r == ST_RD) || (st_r == ST_WR2);

  ////////////////////////////////////////////////////////////////////////
  // decoded view of the picked channel

  assign pick_rx = (ch_r < 4'(pdm_pkg::NUM_RX));
  assign rx_word = rx_data[ch_r*pdm_pkg::DW +: pdm_pkg::DW];

  ////////////////////////////////////////////////////////////////////////
  // pointers and counts

  for (genvar i = 0; i < pdm_pkg::NUM_CH; i++) begin : g_ch
    always_ff @(posedge clk) begin
      if (rst) begin
        cur_addr_r[i] <= pdm_pkg::ADDR_RST;
        cur_cnt_r[i] <= pdm_pkg::CNT_RST;
        nxt_addr_r[i] <= pdm_pkg::ADDR_RST;
        nxt_cnt_r[i] <= pdm_pkg::CNT_RST;
        end_flag_r[i] <= 1'b0;
      end else begin
        if (done_pulse && ch_r == 4'(i)) begin
          if (cur_cnt_r[i] == pdm_pkg::CNT_LAST) begin
            cur_addr_r[i] <= nxt_addr_r[i];
            cur_cnt_r[i] <= nxt_cnt_r[i];
            nxt_cnt_r[i] <= pdm_pkg::CNT_RST;
            end_flag_r[i] <= (nxt_cnt_r[i] == pdm_pkg::CNT_RST);
          end else begin
            cur_addr_r[i] <= cur_addr_r[i] + pdm_pkg::ADDR_STEP;
            cur_cnt_r[i] <= cur_cnt_r[i] - 16'h0001;
          end
        end
        // loads ignored while this channel is mid-transfer,
        // so a load never meets a completion on the same channel
        if (!(st_r != ST_IDLE && ch_r == 4'(i)) && load.ch == 4'(i)) begin
          if (load.load_cur) begin
            cur_addr_r[i] <= load.addr;
            cur_cnt_r[i] <= load.cnt;
            if (load.cnt != pdm_pkg::CNT_RST) begin
              end_flag_r[i] <= 1'b0;
            end
          end
          if (load.load_nxt) begin
            nxt_addr_r[i] <= load.addr;
            nxt_cnt_r[i] <= load.cnt;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit data path through buffer

  // read data is taken at the end of the single strobe cycle
  assign tx_push = (st_r == ST_RD);
  assign tx_pop = !tx_valid_r || tx_ready;
  assign tx_in.ch = ch_r;
  assign tx_in.data = bus_rdata;

  pdm_skid pdm_skid_i (
    .clk(clk),
    .rst(rst),
    .in_valid(tx_push),
    .in_ready(buf_ready),
    .in_word(tx_in),
    .out_valid(buf_valid),
    .out_ready(tx_pop),
    .out_word(buf_word)
  );

  // output register: a word stands until the sink takes it
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_valid_r <= 1'b0;
      tx_word_r <= '0;
    end else if (tx_pop) begin
      tx_valid_r <= buf_valid;
      tx_word_r <= buf_word;
    end
  end

endmodule

// *** testbench/pdm_bus_model.sv ***
/* arbiter and memory model on the engine's bus side
   assumes one strobe per held bus clock, read answered in that cycle */
`timescale 1ns/1ps
module pdm_bus_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic bus_req_r,
  input wire logic bus_strb_r,
  input wire pdm_pkg::pdm_bus_s bus_r,
  output logic bus_gnt,
  output logic [31:0] bus_rdata
);
  logic [1:0] wait_r;
  logic [31:0] noise_r;
  always_ff @(posedge clk) begin
    if (rst || !bus_req_r) wait_r <= slow ? 2'h3 : 2'h0;
    else if (wait_r != 2'h0) wait_r <= wait_r - 2'h1;
  end
  assign bus_gnt = bus_req_r && wait_r == 2'h0;
  ////////////////////////////////////////////////////////////////////////
  // read answer
  // answer stands only in the read strobe cycle; otherwise the data keeps
  // moving, so an early or late sample shows up as a mismatch
  always_ff @(posedge clk) begin
    if (rst) noise_r <= 32'h5A5A5A5A;
    else noise_r <= {noise_r[30:0], ~noise_r[31]};
  end
  assign bus_rdata = (bus_strb_r && !bus_r.wr) ? ~bus_r.addr : noise_r;
endmodule

// *** testbench/pdm_engine_properties.sv ***
/* bus timing and channel acknowledge properties of the engine
   assumes the bound instance's port names */
`timescale 1ns/1ps
module pdm_engine_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_req_r,
  input wire logic bus_gnt,
  input wire logic bus_strb_r,
  input wire pdm_pkg::pdm_bus_s bus_r,
  input wire pdm_pkg::pdm_chvec_t per_ack_r,
  input wire logic tx_valid_r,
  input wire pdm_pkg::pdm_chvec_t end_flag_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr2;
    bus_strb_r && bus_r.wr ##1 bus_strb_r && bus_r.wr ##1 !bus_strb_r;
  endsequence
  a_wr_two_clk:
    assert property ($rose(bus_strb_r) && bus_r.wr |-> s_wr2)
    else $error("write not two clocks");
  a_rd_one_clk:
    assert property ($rose(bus_strb_r) && !bus_r.wr |=> !bus_strb_r)
    else $error("read not one clock");
  a_gnt_strobe:
    assert property (bus_req_r && bus_gnt |=> bus_strb_r)
    else $error("no strobe after grant");
  a_strobe_cause:
    assert property ($rose(bus_strb_r) |-> $past(bus_req_r && bus_gnt))
    else $error("strobe without grant");
  a_ack_single:
    assert property ($onehot0(per_ack_r)) else $error("two acks");
  a_ack_rx_wr:
    assert property (|per_ack_r[5:0] |-> $past(bus_strb_r && bus_r.wr))
    else $error("rx ack without write");
  a_ack_tx_rd:
    assert property (|per_ack_r[10:6] |-> $past(bus_strb_r && !bus_r.wr))
    else $error("tx ack without read");
  a_tx_follow:
    assert property (|per_ack_r[10:6] |-> ##[1:2] tx_valid_r)
    else $error("tx word missing");
  a_end_cause:
    assert property (|(end_flag_r & ~$past(end_flag_r)) |->
      |(per_ack_r | $past(per_ack_r))) else $error("flag without ack");
endmodule
bind pdm_engine pdm_engine_properties pdm_engine_properties_i (
  .clk(clk), .rst(rst), .bus_req_r(bus_req_r), .bus_gnt(bus_gnt),
  .bus_strb_r(bus_strb_r), .bus_r(bus_r), .per_ack_r(per_ack_r),
  .tx_valid_r(tx_valid_r), .end_flag_r(end_flag_r));

// *** testbench/peripheral_dma_channels_test.sv ***
/* self-checking bench: engine and bus model, the bench is the tx sink
   assumes inputs change at the falling edge */
`timescale 1ns/1ps
module peripheral_dma_channels_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic slow = 1'b0;
  logic sink_rdy = 1'b1;
  logic wr_d = 1'b0;
  pdm_pkg::pdm_load_s load = '0;
  pdm_pkg::pdm_chvec_t per_req = '0;
  pdm_pkg::pdm_chvec_t ack, flag;
  pdm_pkg::pdm_bus_s bus;
  pdm_pkg::pdm_word_s txw;
  logic [191:0] rx_data;
  logic [31:0] rdata;
  logic req, gnt, strb, txv;
  logic [63:0] wq[$];
  logic [35:0] tq[$];
  int err_count = 0;
  int num_checks = 0;
  always #10 clk = ~clk;
  for (genvar i = 0; i < 6; i++) begin : g_rx
    assign rx_data[32*i +: 32] = 32'hD00D0000 + 32'(i);
  end
  pdm_engine pdm_engine_i (.clk(clk), .rst(rst), .load(load),
    .per_req(per_req), .rx_data(rx_data), .per_ack_r(ack),
    .bus_req_r(req), .bus_gnt(gnt), .bus_r(bus), .bus_strb_r(strb),
    .bus_rdata(rdata), .tx_valid_r(txv), .tx_ready(sink_rdy),
    .tx_word_r(txw), .end_flag_r(flag));
  pdm_bus_model pdm_bus_model_i (.clk(clk), .rst(rst), .slow(slow),
    .bus_req_r(req), .bus_strb_r(strb), .bus_r(bus), .bus_gnt(gnt),
    .bus_rdata(rdata));
  always @(posedge clk) begin
    if (strb && bus.wr && !wr_d) wq.push_back({bus.addr, bus.wdata});
    if (txv && sink_rdy) tq.push_back(txw);
    wr_d <= strb && bus.wr;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (err_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ld(input int ch, input logic nx, input logic [31:0] a,
                    input logic [15:0] n);
    load = '{load_cur: !nx, load_nxt: nx, ch: 4'(ch), addr: a, cnt: n};
    @(negedge clk);
    load = '0;
    @(negedge clk);
  endtask
  task automatic wait_ack(input int ch, input logic keep);
    int k;
    @(negedge clk);
    for (k = 0; k < 40 && ack === '0; k++) @(negedge clk);
    chk(ack, 11'h1 << ch);
    if (!keep) per_req[ch] = 1'b0;
    if (k == 40) results();
  endtask
  task automatic t_chain();
    int c = pdm_pkg::CH_RX_SP0;
    wq.delete();
    slow = 1'b1;
    ld(c, 1'b0, 32'h100, 16'h2);
    ld(c, 1'b1, 32'h200, 16'h1);
    per_req[c] = 1'b1;
    wait_ack(c, 1'b1);
    chk(flag, '0);
    wait_ack(c, 1'b1);
    wait_ack(c, 1'b0);
    @(negedge clk);
    chk(flag, 11'h1 << c);
    chk(wq[0], {32'h100, 32'hD00D0001});
    chk(wq[1], {32'h104, 32'hD00D0001});
    chk(wq[2], {32'h200, 32'hD00D0001});
  endtask
  task automatic t_prio();
    int i;
    wq.delete();
    tq.delete();
    slow = 1'b0;
    sink_rdy = 1'b0;
    for (i = 0; i < 11; i++) ld(i, 1'b0, 32'h1000 + 32'(i * 64), 16'h1);
    per_req = '1;
    for (i = 0; i < 9; i++) wait_ack(i, 1'b0);
    // sink stalled: buffer and output register hold three words
    repeat (4) @(negedge clk);
    chk(req, 1'b0);
    chk(txv, 1'b1);
    chk(txw, {4'h6, ~(32'h1000 + 32'h180)});
    sink_rdy = 1'b1;
    for (i = 9; i < 11; i++) wait_ack(i, 1'b0);
    repeat (8) @(negedge clk);
    for (i = 0; i < 6; i++)
      chk(wq[i], {32'h1000 + 32'(i * 64), 32'hD00D0000 + 32'(i)});
    for (i = 0; i < 5; i++)
      chk(tq[i], {4'(i + 6), ~(32'h1000 + 32'((i + 6) * 64))});
    chk(flag, 11'h7FF);
    ld(0, 1'b0, 32'h0, 16'h1);
    chk(flag, 11'h7FE);
  endtask
  task automatic t_reset();
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk(flag | ack, '0);
    chk(txv, 1'b0);
    // reset clears the count that the last scenario left on channel 0
    per_req[0] = 1'b1;
    repeat (6) @(negedge clk);
    chk(req, 1'b0);
    per_req[0] = 1'b0;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk(ack | flag, '0);
    t_chain();
    t_prio();
    t_reset();
    results();
  end
endmodule
